// [core/tmc_pkg.sv]
// Package: register map, field layout and types of the timer mode block
// ----------------------------------------------------------------------------
// Summary of operation
// - Pairing bit 0 with double buffering: each compare register updates alone.
// - Pairing bit 1 with double buffering: updates wait until both pending.
// - Writing 0 to the soft capture bit loads the counter into capture zero.
// - Writing 1 to the soft capture bit does nothing; it always reads 1.
// - Capture timing 00 performs no hardware capture.
// - Capture timing 01 captures into zero on input rising edges only.
// - Capture timing 10: rising edge into zero, falling edge into one.
// - Capture timing 11: match output rising into zero, falling into one.
// - Match clear enable 0 never clears the counter on a match.
// - Match clear enable 1 clears the counter when it equals compare one.
// - Clock select 00 input pin, 01 tap one, 10 tap four, 11 tap sixteen.
// ----------------------------------------------------------------------------
`default_nettype none
package tmc_pkg;
    localparam int TMC_AW = 4;
    localparam logic [TMC_AW-1:0] TMC_MODE_ADDR = 4'h0;
    localparam logic [TMC_AW-1:0] TMC_CTRL_ADDR = 4'h4;
    localparam logic [TMC_AW-1:0] TMC_CMP0_ADDR = 4'h8;
    localparam logic [TMC_AW-1:0] TMC_CMP1_ADDR = 4'hC;
    // Read-only words are reached in a second page
    localparam logic [TMC_AW-1:0] TMC_CNT_ADDR = 4'h0;
    localparam logic [TMC_AW-1:0] TMC_CAP0_ADDR = 4'h4;
    localparam logic [TMC_AW-1:0] TMC_CAP1_ADDR = 4'h8;
    localparam logic [TMC_AW-1:0] TMC_STAT_ADDR = 4'hC;
    localparam int TMC_CLK_LSB = 0;
    localparam int TMC_CLE_BIT = 2;
    localparam int TMC_CPM_LSB = 3;
    localparam int TMC_CP_BIT = 5;
    localparam int TMC_RSWR_BIT = 6;
    localparam int TMC_RUN_BIT = 0;
    localparam int TMC_PRUN_BIT = 1;
    localparam int TMC_WBF_BIT = 2;
    localparam logic [1:0] TMC_TAP4_LAST = 2'h3;
    localparam logic [3:0] TMC_TAP16_LAST = 4'hF;

    typedef enum logic [1:0] {
        TMC_CK_PIN = 2'h0,
        TMC_CK_T1 = 2'h1,
        TMC_CK_T4 = 2'h2,
        TMC_CK_T16 = 2'h3
    } tmc_clk_sel_t;

    typedef enum logic [1:0] {
        TMC_CP_OFF = 2'h0,
        TMC_CP_IN_RISE = 2'h1,
        TMC_CP_IN_BOTH = 2'h2,
        TMC_CP_OUT_BOTH = 2'h3
    } tmc_cap_sel_t;

    typedef struct packed {
        logic compare_write_pairing;
        tmc_cap_sel_t capture_timing_select;
        logic match_clear_enable;
        tmc_clk_sel_t count_clock_select;
    } tmc_mode_t;

    localparam tmc_mode_t TMC_MODE_RST = '{1'b0, TMC_CP_OFF, 1'b0, TMC_CK_PIN};

    typedef struct packed {
        logic rise;
        logic fall;
        logic level;
    } tmc_edge_t;
endpackage : tmc_pkg
`default_nettype wire

// [core/tmc_pin_sync.sv]
// Three-stage pin synchroniser with edge detection
`timescale 1ns/1ns
`default_nettype none
module tmc_pin_sync
    import tmc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output tmc_edge_t edge_o
);
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic level_q;
    logic level_d;

    always_comb begin
        sync_d = {sync_q[1:0], pin_i};
        level_d = level_q;
        if (sync_q[2] == sync_q[1]) begin
            level_d = sync_q[1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_q <= 3'h0;
            level_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            level_q <= level_d;
        end
    end

    assign edge_o.rise = level_d & ~level_q;
    assign edge_o.fall = ~level_d & level_q;
    assign edge_o.level = level_q;
endmodule : tmc_pin_sync
`default_nettype wire

// [core/tmc_timer.sv]
// Timer channel: mode register, counter, compare and capture logic
`timescale 1ns/1ns
`default_nettype none
module tmc_timer
    import tmc_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    output logic err_o,
    input wire logic timer_input_pin_i,
    output logic match_output_o
);
    initial begin
        if (CNT_W < 2 || CNT_W > 32) begin
            $error("CNT_W out of range");
        end
    end

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic ack_q, ack_d, err_q, err_d;
    logic [31:0] rdat_q, rdat_d;
    tmc_mode_t mode_q, mode_d;
    logic run_q, run_d, prun_q, prun_d, wbf_q, wbf_d;
    logic [CNT_W-1:0] cmp0_q, cmp0_d, cmp1_q, cmp1_d;
    logic [CNT_W-1:0] buf0_q, buf0_d, buf1_q, buf1_d;
    logic pend0_q, pend0_d, pend1_q, pend1_d;
    logic [CNT_W-1:0] cnt_q, cnt_d, cap0_q, cap0_d, cap1_q, cap1_d;
    logic [3:0] pre_q, pre_d;
    logic out_q, out_d, out_prev_q;
    tmc_edge_t pin_e;

    function automatic logic hit(input logic [31:0] a,
                                 input logic page,
                                 input logic [TMC_AW-1:0] off);
        hit = (a[TMC_AW] == page) && (a[TMC_AW-1:0] == off) &&
              (a[31:TMC_AW+1] == '0);
    endfunction : hit

    logic req, wr, rd, wr_mode, wr_ctrl, wr_cmp0, wr_cmp1, mapped;
    assign req = cyc_i & stb_i & ~ack_q & ~err_q;
    assign wr_mode = req & we_i & sel_i[0] & hit(adr_i, 1'b0, TMC_MODE_ADDR);
    assign wr_ctrl = req & we_i & sel_i[0] & hit(adr_i, 1'b0, TMC_CTRL_ADDR);
    assign wr_cmp0 = req & we_i & hit(adr_i, 1'b0, TMC_CMP0_ADDR);
    assign wr_cmp1 = req & we_i & hit(adr_i, 1'b0, TMC_CMP1_ADDR);
    assign mapped = hit(adr_i, 1'b0, TMC_MODE_ADDR) |
                    hit(adr_i, 1'b0, TMC_CTRL_ADDR) |
                    hit(adr_i, 1'b0, TMC_CMP0_ADDR) |
                    hit(adr_i, 1'b0, TMC_CMP1_ADDR) |
                    (~we_i & (hit(adr_i, 1'b1, TMC_CNT_ADDR) |
                              hit(adr_i, 1'b1, TMC_CAP0_ADDR) |
                              hit(adr_i, 1'b1, TMC_CAP1_ADDR) |
                              hit(adr_i, 1'b1, TMC_STAT_ADDR)));
    assign wr = req & we_i;
    assign rd = req & ~we_i;

    function automatic logic [CNT_W-1:0] merge(input logic [CNT_W-1:0] old,
                                               input logic [31:0] d,
                                               input logic [3:0] s);
        logic [31:0] w;
        w = 32'(old);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                w[8*i +: 8] = d[8*i +: 8];
            end
        end
        merge = w[CNT_W-1:0];
    endfunction : merge

    always_comb begin
        ack_d = req & mapped;
        err_d = req & ~mapped;
        rdat_d = 32'h0;
        if (rd) begin
            if (hit(adr_i, 1'b0, TMC_MODE_ADDR)) begin
                rdat_d = 32'({mode_q.compare_write_pairing, 1'b0, mode_q[4:0]});
                rdat_d[TMC_CP_BIT] = 1'b1;
            end else if (hit(adr_i, 1'b0, TMC_CTRL_ADDR)) begin
                rdat_d[TMC_RUN_BIT] = run_q;
                rdat_d[TMC_PRUN_BIT] = prun_q;
                rdat_d[TMC_WBF_BIT] = wbf_q;
            end else if (hit(adr_i, 1'b0, TMC_CMP0_ADDR)) begin
                rdat_d = 32'(cmp0_q);
            end else if (hit(adr_i, 1'b0, TMC_CMP1_ADDR)) begin
                rdat_d = 32'(cmp1_q);
            end else if (hit(adr_i, 1'b1, TMC_CNT_ADDR)) begin
                rdat_d = 32'(cnt_q);
            end else if (hit(adr_i, 1'b1, TMC_CAP0_ADDR)) begin
                rdat_d = 32'(cap0_q);
            end else if (hit(adr_i, 1'b1, TMC_CAP1_ADDR)) begin
                rdat_d = 32'(cap1_q);
            end else if (hit(adr_i, 1'b1, TMC_STAT_ADDR)) begin
                rdat_d = {29'h0, pend1_q, pend0_q, out_q};
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode, control and compare registers
    // ------------------------------------------------------------------
    logic upd0, upd1, cnt_tick;

    always_comb begin
        mode_d = mode_q;
        run_d = run_q;
        prun_d = prun_q;
        wbf_d = wbf_q;
        if (wr_mode) begin
            mode_d = tmc_mode_t'({dat_i[TMC_RSWR_BIT],
                                  dat_i[TMC_CPM_LSB +: 2],
                                  dat_i[TMC_CLE_BIT],
                                  dat_i[TMC_CLK_LSB +: 2]});
        end
        if (wr_ctrl) begin
            run_d = dat_i[TMC_RUN_BIT];
            prun_d = dat_i[TMC_PRUN_BIT];
            wbf_d = dat_i[TMC_WBF_BIT];
        end
    end

    // Buffered compare values move on counter clear (period end)
    logic period_end;
    always_comb begin
        cmp0_d = cmp0_q;
        cmp1_d = cmp1_q;
        buf0_d = buf0_q;
        buf1_d = buf1_q;
        pend0_d = pend0_q;
        pend1_d = pend1_q;
        upd0 = 1'b0;
        upd1 = 1'b0;
        if (wbf_q) begin
            if (mode_q.compare_write_pairing) begin
                upd0 = period_end & pend0_q & pend1_q;
                upd1 = upd0;
            end else begin
                upd0 = period_end & pend0_q;
                upd1 = period_end & pend1_q;
            end
        end
        if (upd0) begin
            cmp0_d = buf0_q;
            pend0_d = 1'b0;
        end
        if (upd1) begin
            cmp1_d = buf1_q;
            pend1_d = 1'b0;
        end
        if (wr_cmp0) begin
            if (wbf_q) begin
                buf0_d = merge(buf0_q, dat_i, sel_i);
                pend0_d = 1'b1;
            end else begin
                cmp0_d = merge(cmp0_q, dat_i, sel_i);
            end
        end
        if (wr_cmp1) begin
            if (wbf_q) begin
                buf1_d = merge(buf1_q, dat_i, sel_i);
                pend1_d = 1'b1;
            end else begin
                cmp1_d = merge(cmp1_q, dat_i, sel_i);
            end
        end
    end

    // ------------------------------------------------------------------
    // Prescaler, counter, match output and captures
    // ------------------------------------------------------------------
    tmc_pin_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(timer_input_pin_i),
        .edge_o(pin_e)
    );

    logic match0, match1, soft_cap, out_rise, out_fall;
    assign match0 = run_q & cnt_tick & (cnt_q == cmp0_q);
    assign match1 = run_q & cnt_tick & (cnt_q == cmp1_q);
    assign period_end = match1 & mode_q.match_clear_enable;
    assign soft_cap = wr_mode & ~dat_i[TMC_CP_BIT];
    assign out_rise = out_q & ~out_prev_q;
    assign out_fall = ~out_q & out_prev_q;

    always_comb begin
        pre_d = prun_q ? 4'(pre_q + 4'h1) : 4'h0;
        case (mode_q.count_clock_select)
            TMC_CK_PIN: cnt_tick = pin_e.rise;
            TMC_CK_T1: cnt_tick = prun_q;
            TMC_CK_T4: cnt_tick = prun_q & (pre_q[1:0] == TMC_TAP4_LAST);
            TMC_CK_T16: cnt_tick = prun_q & (pre_q == TMC_TAP16_LAST);
            default: cnt_tick = 1'b0;
        endcase
        cnt_d = cnt_q;
        if (!run_q) begin
            cnt_d = '0;
        end else if (cnt_tick) begin
            cnt_d = period_end ? '0 : CNT_W'(cnt_q + 1'b1);
        end
        out_d = out_q;
        if (match0) begin
            out_d = 1'b1;
        end else if (match1) begin
            out_d = 1'b0;
        end
        cap0_d = cap0_q;
        cap1_d = cap1_q;
        if (soft_cap) begin
            cap0_d = cnt_q;
        end
        case (mode_q.capture_timing_select)
            TMC_CP_IN_RISE: begin
                if (pin_e.rise) cap0_d = cnt_q;
            end
            TMC_CP_IN_BOTH: begin
                if (pin_e.rise) cap0_d = cnt_q;
                if (pin_e.fall) cap1_d = cnt_q;
            end
            TMC_CP_OUT_BOTH: begin
                if (out_rise) cap0_d = cnt_q;
                if (out_fall) cap1_d = cnt_q;
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rdat_q <= 32'h0;
            mode_q <= TMC_MODE_RST;
            run_q <= 1'b0;
            prun_q <= 1'b0;
            wbf_q <= 1'b0;
            cmp0_q <= '0;
            cmp1_q <= '0;
            buf0_q <= '0;
            buf1_q <= '0;
            pend0_q <= 1'b0;
            pend1_q <= 1'b0;
            cnt_q <= '0;
            cap0_q <= '0;
            cap1_q <= '0;
            pre_q <= 4'h0;
            out_q <= 1'b0;
            out_prev_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
            err_q <= err_d;
            rdat_q <= rdat_d;
            mode_q <= mode_d;
            run_q <= run_d;
            prun_q <= prun_d;
            wbf_q <= wbf_d;
            cmp0_q <= cmp0_d;
            cmp1_q <= cmp1_d;
            buf0_q <= buf0_d;
            buf1_q <= buf1_d;
            pend0_q <= pend0_d;
            pend1_q <= pend1_d;
            cnt_q <= cnt_d;
            cap0_q <= cap0_d;
            cap1_q <= cap1_d;
            pre_q <= pre_d;
            out_q <= out_d;
            out_prev_q <= out_q;
        end
    end

    assign ack_o = ack_q;
    assign err_o = err_q;
    assign dat_o = rdat_q;
    assign match_output_o = out_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    pair_block_a: assert property (
        wbf_q && mode_q.compare_write_pairing && !(pend0_q && pend1_q)
        && !wr_cmp0 && !wr_cmp1 |=> $stable(cmp0_q) && $stable(cmp1_q))
        else $error("paired update happened early");
    indep_upd_a: assert property (
        wbf_q && !mode_q.compare_write_pairing && period_end && pend0_q
        && !wr_cmp0 |=> cmp0_q == $past(buf0_q))
        else $error("compare zero missed its update");
    soft_cap_a: assert property (
        soft_cap && mode_q.capture_timing_select == TMC_CP_OFF
        |=> cap0_q == $past(cnt_q))
        else $error("soft capture lost");
    cp_reads_one_a: assert property (
        rd && hit(adr_i, 1'b0, TMC_MODE_ADDR) |=> dat_o[TMC_CP_BIT])
        else $error("soft capture bit read zero");
    no_hw_cap_a: assert property (
        mode_q.capture_timing_select == TMC_CP_OFF && !soft_cap
        |=> $stable(cap0_q) && $stable(cap1_q))
        else $error("capture while disabled");
    rise_cap_a: assert property (
        mode_q.capture_timing_select == TMC_CP_IN_RISE && pin_e.rise
        |=> cap0_q == $past(cnt_q))
        else $error("rising edge capture missed");
    fall_cap_a: assert property (
        mode_q.capture_timing_select == TMC_CP_IN_BOTH && pin_e.fall
        |=> cap1_q == $past(cnt_q))
        else $error("falling edge capture missed");
    out_cap_a: assert property (
        mode_q.capture_timing_select == TMC_CP_OUT_BOTH && out_fall
        |=> cap1_q == $past(cnt_q))
        else $error("match output capture missed");
    no_clear_a: assert property (
        run_q && cnt_tick && !mode_q.match_clear_enable && !wr_ctrl
        && cnt_q != '1 |=> cnt_q != '0)
        else $error("counter cleared with clear off");
    match_clear_a: assert property (
        period_end && !wr_ctrl |=> cnt_q == '0)
        else $error("counter not cleared on match");
    tap4_rate_a: assert property (
        run_q && prun_q && mode_q.count_clock_select == TMC_CK_T4
        && cnt_tick |=> !cnt_tick [*3])
        else $error("tap four too fast");

    pair_cv: cover property (upd0 && upd1 && mode_q.compare_write_pairing);
    soft_cv: cover property (soft_cap);
    out_cv: cover property (out_rise ##[1:200] out_fall);
    clear_cv: cover property (period_end);
endmodule : tmc_timer
`default_nettype wire

// [test/tmc_pin_model.sv]
// Partner model: the signal source on the timer input pin
`timescale 1ns/1ns
`default_nettype none
module tmc_pin_model (
    input wire logic clk_i,
    output logic pin_o
);
    initial pin_o = 1'b0;
    // Each level lasts four clocks so no edge is lost in the synchroniser
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk_i);
            pin_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            pin_o <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask : pulses
endmodule : tmc_pin_model
`default_nettype wire

// [test/testbench.sv]
// Testbench: mode register, count sources, captures and compare buffering
`timescale 1ns/1ns
`default_nettype none
module testbench import tmc_pkg::*;;
    localparam logic [31:0] A_MODE = 32'h0;
    localparam logic [31:0] A_CTRL = 32'h4;
    localparam logic [31:0] A_CMP0 = 32'h8;
    localparam logic [31:0] A_CMP1 = 32'hC;
    localparam logic [31:0] A_CNT = 32'h10;
    localparam logic [31:0] A_CAP0 = 32'h14;
    localparam logic [31:0] A_CAP1 = 32'h18;
    localparam logic [31:0] A_STAT = 32'h1C;
    localparam logic [31:0] RUN = 32'h3;
    localparam logic [31:0] WBF = 32'h4;
    logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, err_o, pin, match_o;
    logic [31:0] adr_i, dat_i, dat_o;
    logic [3:0] sel_i;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;
    logic [31:0] q, a, b;
    // ------------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------------
    tmc_timer tmc_timer_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
        .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .err_o(err_o),
        .timer_input_pin_i(pin), .match_output_o(match_o));
    tmc_pin_model tmc_pin_model_i (.clk_i(clk_i), .pin_o(pin));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic finish_test;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] g, input logic [31:0] x,
                       input string m);
        checks++;
        if (g !== x) begin
            error_cnt++;
            $display("mismatch t=%0t %s got %h exp %h", $time, m, g, x);
        end
    endtask : chk
    task automatic rng(input logic [31:0] g, input int lo, input int hi,
                       input string m);
        checks++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            error_cnt++;
            $display("mismatch t=%0t %s got %0d", $time, m, g);
        end
    endtask : rng
    // Classic cycle; answer is sampled at a rising edge, released right after
    task automatic wb(input logic w, input logic [31:0] ad,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= ad;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
        r = dat_o;
        e = err_o;
        if (n >= 20) begin
            error_cnt++;
            $display("mismatch t=%0t no bus answer", $time);
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb
    task automatic wr(input logic [31:0] ad, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        wb(1'b1, ad, d, r, e);
        chk({31'h0, e}, 32'h0, "write refused");
    endtask : wr
    task automatic rd(input logic [31:0] ad, output logic [31:0] r);
        logic e;
        wb(1'b0, ad, 32'h0, r, e);
        chk({31'h0, e}, 32'h0, "read refused");
    endtask : rd
    function automatic logic [31:0] md(input logic [1:0] cpm,
        input logic cle, input logic [1:0] ck, input logic pr);
        md = 32'h20 | ({31'h0, pr} << TMC_RSWR_BIT)
            | ({30'h0, cpm} << TMC_CPM_LSB)
            | ({31'h0, cle} << TMC_CLE_BIT) | {30'h0, ck};
    endfunction : md
    task automatic setup(input logic [31:0] m, input logic [31:0] c);
        wr(A_CTRL, 32'h0);
        wr(A_MODE, m);
        wr(A_CTRL, c);
    endtask : setup
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        logic e;
        rd(A_MODE, q);
        chk(q, 32'h20, "mode reset");
        wr(A_MODE, 32'hFFFFFFFF);
        rd(A_MODE, q);
        chk(q, 32'h7F, "mode all ones");
        wr(A_MODE, 32'h20);
        wb(1'b1, A_CNT, 32'h5, q, e);
        chk({31'h0, e}, 32'h1, "read-only write taken");
    endtask : t_regs
    task automatic t_pin;
        setup(md(2'h0, 1'b0, 2'h0, 1'b0), RUN);
        tmc_pin_model_i.pulses(5);
        repeat (6) @(posedge clk_i);
        rd(A_CNT, q);
        chk(q, 32'h5, "pin count");
        rd(A_CAP0, q);
        chk(q, 32'h0, "capture while off");
        wr(A_MODE, md(2'h0, 1'b0, 2'h0, 1'b0) & ~32'h20);
        rd(A_CAP0, q);
        chk(q, 32'h5, "soft capture");
        tmc_pin_model_i.pulses(2);
        repeat (6) @(posedge clk_i);
        wr(A_MODE, md(2'h0, 1'b0, 2'h0, 1'b0));
        rd(A_CAP0, q);
        chk(q, 32'h5, "capture on one");
        rd(A_CNT, q);
        chk(q, 32'h7, "pin count more");
    endtask : t_pin
    task automatic t_edges;
        setup(md(2'h2, 1'b0, 2'h0, 1'b0), RUN);
        tmc_pin_model_i.pulses(3);
        repeat (6) @(posedge clk_i);
        rd(A_CAP1, q);
        chk(q, 32'h3, "fall capture");
        rd(A_CAP0, q);
        rng(q, 2, 3, "rise capture");
        setup(md(2'h1, 1'b0, 2'h0, 1'b0), RUN);
        tmc_pin_model_i.pulses(6);
        repeat (6) @(posedge clk_i);
        rd(A_CAP1, q);
        chk(q, 32'h3, "fall ignored");
        rd(A_CAP0, q);
        rng(q, 5, 6, "rise only capture");
    endtask : t_edges
    // Counting rate over a fixed gap, for each prescaler tap
    task automatic t_taps;
        for (int s = 1; s < 4; s++) begin
            int dv;
            dv = 1 << (2 * (s - 1));
            setup(md(2'h0, 1'b0, 2'(s), 1'b0), RUN);
            rd(A_CNT, a);
            repeat (64) @(posedge clk_i);
            rd(A_CNT, b);
            rng(b - a, 64 / dv, 72 / dv + 1, "tap rate");
        end
    endtask : t_taps
    task automatic t_clear;
        int n;
        wr(A_CTRL, 32'h0);
        wr(A_CMP0, 32'h4);
        wr(A_CMP1, 32'h9);
        setup(md(2'h3, 1'b1, 2'h1, 1'b0), RUN);
        repeat (40) @(posedge clk_i);
        repeat (5) begin
            rd(A_CNT, q);
            rng(q, 0, 9, "clear on compare one");
        end
        rd(A_CAP0, q);
        rng(q, 3, 6, "match rise capture");
        rd(A_CAP1, q);
        chk({31'h0, q <= 1 || (q >= 8 && q <= 10)}, 32'h1, "match fall");
        // Match output is high from compare zero up to compare one
        n = 0;
        repeat (10) begin
            @(posedge clk_i);
            if (match_o === 1'b1) begin
                n++;
            end
        end
        chk(n, 32'h5, "match output duty");
        setup(md(2'h0, 1'b0, 2'h1, 1'b0), RUN);
        repeat (40) @(posedge clk_i);
        rd(A_CNT, q);
        rng(q, 30, 60, "no clear");
    endtask : t_clear
    task automatic t_dbuf;
        setup(md(2'h0, 1'b1, 2'h1, 1'b0), RUN | WBF);
        wr(A_CMP0, 32'h5);
        repeat (30) @(posedge clk_i);
        rd(A_STAT, q);
        chk({30'h0, q[2:1]}, 32'h0, "single update");
        setup(md(2'h0, 1'b1, 2'h1, 1'b1), RUN | WBF);
        wr(A_CMP0, 32'h6);
        repeat (30) @(posedge clk_i);
        rd(A_STAT, q);
        chk({30'h0, q[2:1]}, 32'h1, "paired wait");
        wr(A_CMP1, 32'hC);
        repeat (40) @(posedge clk_i);
        rd(A_STAT, q);
        chk({30'h0, q[2:1]}, 32'h0, "paired update");
    endtask : t_dbuf
    // ------------------------------------------------------------------
    // Sequence and hang guard
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            $display("mismatch t=%0t timeout", $time);
            finish_test();
        end
    end
    initial begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 32'h0;
        dat_i = 32'h0;
        sel_i = 4'hF;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_pin();
        t_edges();
        t_taps();
        t_clear();
        t_dbuf();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
